/* design/eba_core.sv */
// Eight-bit ALU datapath with working register, flags and an Avalon-MM status port
`timescale 1ns/10ps
`include "eba_defines.svh"

module eba_core
    import eba_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Execute request from decoder
    input wire logic EXEC_I,
    input eba_op_t OP_I,
    input wire logic [7:0] IMM_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [2:0] BIT_I,
    input wire logic [7:0] MEM_RDATA_I,
    input wire logic [7:0] IO_RDATA_I,
    input wire logic IO_DIR_OUT_I,
    // Results toward memory, IO space and sequencer
    output logic [7:0] WREG_O,
    output logic FLAG_Z_O,
    output logic FLAG_C_O,
    output logic FLAG_HALF_CARRY_O,
    output logic FLAG_SIGNED_RANGE_O,
    output logic MEM_WE_O,
    output logic IO_WE_O,
    output logic [7:0] WADDR_O,
    output logic [7:0] WDATA_O,
    output logic SKIP_O,
    output logic BIT_ERR_O,
    // Avalon-MM slave
    input wire logic [3:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] WRITEDATA_I,
    input wire logic [3:0] BYTEENABLE_I,
    output logic [31:0] READDATA_O,
    output logic WAITREQUEST_O
);

    eba_state_t st;
    eba_state_t next_st;

    // Add with carry in; carry and half carry are plain carry-outs
    function automatic eba_arith_t eba_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        eba_arith_t r;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[`EBA_NIB_LO]} + {1'b0, b[`EBA_NIB_LO]} + {4'h0, ci};
        r.res = s[7:0];
        r.c = s[`EBA_CY_BIT];
        r.half_carry = h[`EBA_HC_BIT];
        r.signed_range = (a[`EBA_MSB] == b[`EBA_MSB]) && (s[`EBA_MSB] != a[`EBA_MSB]);
        return r;
    endfunction

    // Subtract with borrow in; carry and half carry report borrows
    function automatic eba_arith_t eba_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic bi);
        logic [8:0] s;
        logic [4:0] h;
        eba_arith_t r;
        s = {1'b0, a} - {1'b0, b} - {8'h00, bi};
        h = {1'b0, a[`EBA_NIB_LO]} - {1'b0, b[`EBA_NIB_LO]} - {4'h0, bi};
        r.res = s[7:0];
        r.c = s[`EBA_CY_BIT];
        r.half_carry = h[`EBA_HC_BIT];
        r.signed_range = (a[`EBA_MSB] != b[`EBA_MSB]) && (s[`EBA_MSB] != a[`EBA_MSB]);
        return r;
    endfunction

    logic bus_req;
    logic bus_take;
    logic bit_op;
    logic bit_bad;

    // Requests wait one cycle so that read data always comes from a flop
    assign bus_req = READ_I || WRITE_I;
    assign bus_take = bus_req && st.bus_ack;
    assign WAITREQUEST_O = bus_req && !st.bus_ack;

    // Bit-addressed operations reach only the low part of the address space
    assign bit_op = (OP_I == OP_BCLR_IO) || (OP_I == OP_BSET_IO) || (OP_I == OP_BCLR_M)
                    || (OP_I == OP_BSET_M) || (OP_I == OP_SWAPC_IO);
    assign bit_bad = EXEC_I && bit_op && (ADDR_I > `EBA_BIT_ADDR_MAX);

    // Next-state logic: execution, then bus access
    always_comb begin
        eba_arith_t ar;
        logic [7:0] res;
        logic [7:0] mask;
        logic wr_a;
        logic wr_m;
        logic wr_io;
        logic upd_all;
        logic upd_z;
        logic upd_c;
        logic new_c;
        ar = '0;
        res = `EBA_BYTE_ZERO;
        mask = `EBA_BYTE_ONE << BIT_I;
        wr_a = 1'b0;
        wr_m = 1'b0;
        wr_io = 1'b0;
        upd_all = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        new_c = st.c;
        next_st = st;
        next_st.mem_we = 1'b0;
        next_st.io_we = 1'b0;
        next_st.skip = 1'b0;
        next_st.bus_ack = bus_req && !st.bus_ack;
        if (EXEC_I && !bit_bad) begin
            case (OP_I)
                OP_ADD_AI: begin ar = eba_add(st.wreg, IMM_I, 1'b0); wr_a = 1'b1; end
                OP_ADD_AM: begin ar = eba_add(st.wreg, MEM_RDATA_I, 1'b0); wr_a = 1'b1; end
                OP_ADD_MA: begin ar = eba_add(st.wreg, MEM_RDATA_I, 1'b0); wr_m = 1'b1; end
                OP_ADDC_AM: begin ar = eba_add(st.wreg, MEM_RDATA_I, st.c); wr_a = 1'b1; end
                OP_ADDC_MA: begin ar = eba_add(st.wreg, MEM_RDATA_I, st.c); wr_m = 1'b1; end
                OP_ADDC_A: begin ar = eba_add(st.wreg, `EBA_BYTE_ZERO, st.c); wr_a = 1'b1; end
                OP_ADDC_M: begin ar = eba_add(MEM_RDATA_I, `EBA_BYTE_ZERO, st.c); wr_m = 1'b1; end
                OP_NADD_AM: begin ar = eba_sub(MEM_RDATA_I, st.wreg, 1'b0); wr_a = 1'b1; end
                OP_NADD_MA: begin ar = eba_sub(st.wreg, MEM_RDATA_I, 1'b0); wr_m = 1'b1; end
                OP_SUB_AI: begin ar = eba_sub(st.wreg, IMM_I, 1'b0); wr_a = 1'b1; end
                OP_SUB_AM: begin ar = eba_sub(st.wreg, MEM_RDATA_I, 1'b0); wr_a = 1'b1; end
                OP_SUB_MA: begin ar = eba_sub(MEM_RDATA_I, st.wreg, 1'b0); wr_m = 1'b1; end
                OP_SUBC_AM: begin ar = eba_sub(st.wreg, MEM_RDATA_I, st.c); wr_a = 1'b1; end
                OP_SUBC_MA: begin ar = eba_sub(MEM_RDATA_I, st.wreg, st.c); wr_m = 1'b1; end
                OP_SUBC_A: begin ar = eba_sub(st.wreg, `EBA_BYTE_ZERO, st.c); wr_a = 1'b1; end
                OP_SUBC_M: begin ar = eba_sub(MEM_RDATA_I, `EBA_BYTE_ZERO, st.c); wr_m = 1'b1; end
                OP_INC_M: begin ar = eba_add(MEM_RDATA_I, `EBA_BYTE_ONE, 1'b0); wr_m = 1'b1; end
                OP_DEC_M: begin ar = eba_sub(MEM_RDATA_I, `EBA_BYTE_ONE, 1'b0); wr_m = 1'b1; end
                OP_COMP_AM: ar = eba_sub(st.wreg, MEM_RDATA_I, 1'b0);
                OP_COMP_MA: ar = eba_sub(MEM_RDATA_I, st.wreg, 1'b0);
                OP_CEQSN_AI: begin
                    ar = eba_sub(st.wreg, IMM_I, 1'b0);
                    next_st.skip = (st.wreg == IMM_I);
                end
                OP_CLEAR_M: begin res = `EBA_BYTE_ZERO; wr_m = 1'b1; end
                OP_SHR_A: begin res = {1'b0, st.wreg[`EBA_HI_SEVEN]}; new_c = st.wreg[`EBA_LSB]; end
                OP_SHR_M: begin res = {1'b0, MEM_RDATA_I[`EBA_HI_SEVEN]}; new_c = MEM_RDATA_I[`EBA_LSB]; end
                OP_RRC_A: begin res = {st.c, st.wreg[`EBA_HI_SEVEN]}; new_c = st.wreg[`EBA_LSB]; end
                OP_RRC_M: begin res = {st.c, MEM_RDATA_I[`EBA_HI_SEVEN]}; new_c = MEM_RDATA_I[`EBA_LSB]; end
                OP_SHL_A: begin res = {st.wreg[`EBA_LO_SEVEN], 1'b0}; new_c = st.wreg[`EBA_MSB]; end
                OP_SHL_M: begin res = {MEM_RDATA_I[`EBA_LO_SEVEN], 1'b0}; new_c = MEM_RDATA_I[`EBA_MSB]; end
                OP_RLC_A: begin res = {st.wreg[`EBA_LO_SEVEN], st.c}; new_c = st.wreg[`EBA_MSB]; end
                OP_RLC_M: begin res = {MEM_RDATA_I[`EBA_LO_SEVEN], st.c}; new_c = MEM_RDATA_I[`EBA_MSB]; end
                OP_SWAP_A: begin res = {st.wreg[`EBA_NIB_LO], st.wreg[`EBA_NIB_HI]}; wr_a = 1'b1; end
                OP_AND_AI: begin res = st.wreg & IMM_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_AND_AM: begin res = st.wreg & MEM_RDATA_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_AND_MA: begin res = st.wreg & MEM_RDATA_I; wr_m = 1'b1; upd_z = 1'b1; end
                OP_OR_AI: begin res = st.wreg | IMM_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_OR_AM: begin res = st.wreg | MEM_RDATA_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_OR_MA: begin res = st.wreg | MEM_RDATA_I; wr_m = 1'b1; upd_z = 1'b1; end
                OP_XOR_AI: begin res = st.wreg ^ IMM_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_XOR_AM: begin res = st.wreg ^ MEM_RDATA_I; wr_a = 1'b1; upd_z = 1'b1; end
                OP_XOR_MA: begin res = st.wreg ^ MEM_RDATA_I; wr_m = 1'b1; upd_z = 1'b1; end
                OP_XOR_IOA: begin res = st.wreg ^ IO_RDATA_I; wr_io = 1'b1; end
                OP_NOT_A: begin res = ~st.wreg; wr_a = 1'b1; upd_z = 1'b1; end
                OP_NOT_M: begin res = ~MEM_RDATA_I; wr_m = 1'b1; upd_z = 1'b1; end
                OP_NEG_A: begin res = `EBA_BYTE_ZERO - st.wreg; wr_a = 1'b1; upd_z = 1'b1; end
                OP_NEG_M: begin res = `EBA_BYTE_ZERO - MEM_RDATA_I; wr_m = 1'b1; upd_z = 1'b1; end
                OP_BCLR_IO: begin res = IO_RDATA_I & ~mask; wr_io = 1'b1; end
                OP_BSET_IO: begin res = IO_RDATA_I | mask; wr_io = 1'b1; end
                OP_BCLR_M: begin res = MEM_RDATA_I & ~mask; wr_m = 1'b1; end
                OP_BSET_M: begin res = MEM_RDATA_I | mask; wr_m = 1'b1; end
                OP_SWAPC_IO: begin
                    // Output pin takes carry; an input pin only loads carry
                    new_c = IO_RDATA_I[BIT_I];
                    res = st.c ? (IO_RDATA_I | mask) : (IO_RDATA_I & ~mask);
                    wr_io = IO_DIR_OUT_I;
                end
                default: res = st.wreg;
            endcase
            // Shift and rotate groups write back to the operand they read
            case (OP_I)
                OP_SHR_A, OP_RRC_A, OP_SHL_A, OP_RLC_A: begin wr_a = 1'b1; upd_c = 1'b1; end
                OP_SHR_M, OP_RRC_M, OP_SHL_M, OP_RLC_M: begin wr_m = 1'b1; upd_c = 1'b1; end
                OP_SWAPC_IO: upd_c = 1'b1;
                OP_NOP, OP_CLEAR_M, OP_SWAP_A, OP_XOR_IOA, OP_BCLR_IO, OP_BSET_IO, OP_BCLR_M,
                OP_BSET_M, OP_AND_AI, OP_AND_AM, OP_AND_MA, OP_OR_AI, OP_OR_AM, OP_OR_MA,
                OP_XOR_AI, OP_XOR_AM, OP_XOR_MA, OP_NOT_A, OP_NOT_M, OP_NEG_A, OP_NEG_M:
                    upd_all = 1'b0;
                default: upd_all = 1'b1;
            endcase
            if (upd_all) begin
                res = ar.res;
                next_st.z = (ar.res == `EBA_BYTE_ZERO);
                next_st.c = ar.c;
                next_st.half_carry = ar.half_carry;
                next_st.signed_range = ar.signed_range;
            end
            if (upd_z) begin
                next_st.z = (res == `EBA_BYTE_ZERO);
            end
            if (upd_c) begin
                next_st.c = new_c;
            end
            if (wr_a) begin
                next_st.wreg = res;
            end
            next_st.mem_we = wr_m;
            next_st.io_we = wr_io;
            if (wr_m || wr_io) begin
                next_st.waddr = ADDR_I;
                next_st.wdata = res;
            end
        end
        // Software writes to the working register and flags yield to execution
        if (bus_take && WRITE_I && BYTEENABLE_I[0] && !EXEC_I) begin
            if (ADDRESS_I == `EBA_REG_WREG) begin
                next_st.wreg = WRITEDATA_I[7:0];
            end
            if (ADDRESS_I == `EBA_REG_FLAGS) begin
                next_st.z = WRITEDATA_I[`EBA_FLAG_Z];
                next_st.c = WRITEDATA_I[`EBA_FLAG_C];
                next_st.half_carry = WRITEDATA_I[`EBA_FLAG_HALF_CARRY];
                next_st.signed_range = WRITEDATA_I[`EBA_FLAG_SIGNED_RANGE];
            end
        end
        // Sticky refusal flag: a new refusal wins over a clear in the same cycle
        if (bus_take && WRITE_I && BYTEENABLE_I[0] && (ADDRESS_I == `EBA_REG_STATUS)
            && WRITEDATA_I[`EBA_STS_BITERR]) begin
            next_st.bit_err = 1'b0;
        end
        if (bit_bad) begin
            next_st.bit_err = 1'b1;
        end
        // Read data captured during the wait cycle; unmapped reads give zero
        if (READ_I && !st.bus_ack) begin
            next_st.rdata = `EBA_WORD_ZERO;
            case (ADDRESS_I)
                `EBA_REG_WREG: next_st.rdata[7:0] = st.wreg;
                `EBA_REG_FLAGS: next_st.rdata[`EBA_FLAG_SIGNED_RANGE:`EBA_FLAG_Z] =
                    {st.signed_range, st.half_carry, st.c, st.z};
                `EBA_REG_STATUS: next_st.rdata[`EBA_STS_BITERR:`EBA_STS_SKIP] = {st.bit_err, st.skip};
                default: next_st.rdata = `EBA_WORD_ZERO;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs other than WAITREQUEST_O come straight from the state flops
    assign WREG_O = st.wreg;
    assign FLAG_Z_O = st.z;
    assign FLAG_C_O = st.c;
    assign FLAG_HALF_CARRY_O = st.half_carry;
    assign FLAG_SIGNED_RANGE_O = st.signed_range;
    assign MEM_WE_O = st.mem_we;
    assign IO_WE_O = st.io_we;
    assign WADDR_O = st.waddr;
    assign WDATA_O = st.wdata;
    assign SKIP_O = st.skip;
    assign BIT_ERR_O = st.bit_err;
    assign READDATA_O = st.rdata;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_add_imm_sum: assert property (EXEC_I && OP_I == OP_ADD_AI |=>
        WREG_O == 8'($past(WREG_O) + $past(IMM_I))) else $error("add immediate sum wrong");
    a_sub_borrow_flag: assert property (EXEC_I && OP_I == OP_SUB_AI |=>
        FLAG_C_O == ($past(WREG_O) < $past(IMM_I))) else $error("borrow flag wrong");
    a_clear_keeps_flags: assert property (EXEC_I && OP_I == OP_CLEAR_M |=>
        MEM_WE_O && WDATA_O == `EBA_BYTE_ZERO && $stable({FLAG_Z_O, FLAG_C_O,
        FLAG_HALF_CARRY_O, FLAG_SIGNED_RANGE_O})) else $error("clear wrong");
    a_shr_carry_out: assert property (EXEC_I && OP_I == OP_SHR_A |=>
        FLAG_C_O == $past(WREG_O[`EBA_LSB]) && !WREG_O[`EBA_MSB] && $stable(FLAG_Z_O))
        else $error("right shift wrong");
    a_rlc_carry_in: assert property (EXEC_I && OP_I == OP_RLC_A |=>
        WREG_O[`EBA_LSB] == $past(FLAG_C_O) && FLAG_C_O == $past(WREG_O[`EBA_MSB]))
        else $error("left rotate wrong");
    a_swap_nibbles: assert property (EXEC_I && OP_I == OP_SWAP_A |=>
        WREG_O == {$past(WREG_O[`EBA_NIB_LO]), $past(WREG_O[`EBA_NIB_HI])} && $stable(FLAG_C_O))
        else $error("nibble swap wrong");
    a_xor_io_write: assert property (EXEC_I && OP_I == OP_XOR_IOA |=>
        IO_WE_O && WDATA_O == ($past(IO_RDATA_I) ^ $past(WREG_O)) && !MEM_WE_O)
        else $error("xor to io wrong");
    a_comp_no_store: assert property (EXEC_I && (OP_I == OP_COMP_AM || OP_I == OP_COMP_MA)
        |=> !MEM_WE_O && !IO_WE_O && $stable(WREG_O)) else $error("compare stored");
    a_ceqsn_skip_eq: assert property (EXEC_I && OP_I == OP_CEQSN_AI |=>
        SKIP_O == ($past(WREG_O) == $past(IMM_I)) && FLAG_Z_O == SKIP_O)
        else $error("skip wrong");
    a_bit_range_block: assert property (EXEC_I && bit_op && ADDR_I > `EBA_BIT_ADDR_MAX
        |=> !MEM_WE_O && !IO_WE_O && BIT_ERR_O) else $error("bit range not enforced");
    a_logic_keep_carry: assert property (EXEC_I && OP_I == OP_AND_AM |=>
        $stable({FLAG_C_O, FLAG_HALF_CARRY_O, FLAG_SIGNED_RANGE_O})
        && FLAG_Z_O == (WREG_O == `EBA_BYTE_ZERO))
        else $error("logic flags wrong");
    a_bus_one_wait: assert property (bus_req && WAITREQUEST_O |=> !WAITREQUEST_O)
        else $error("bus wait too long");

    c_skip_taken: cover property (EXEC_I && OP_I == OP_CEQSN_AI ##1 SKIP_O);
    c_add_overflow: cover property (EXEC_I && OP_I == OP_ADD_AM ##1 FLAG_SIGNED_RANGE_O);
    c_swapc_out: cover property (EXEC_I && OP_I == OP_SWAPC_IO && IO_DIR_OUT_I ##1 IO_WE_O);
    c_bus_read: cover property (READ_I && !WAITREQUEST_O);
endmodule

/* inc/eba_defines.svh */
// Constants for the eight-bit ALU datapath: offsets, field positions, values
`ifndef EBA_DEFINES_SVH
`define EBA_DEFINES_SVH
`define EBA_BYTE_ZERO 8'h00
`define EBA_BYTE_ONE 8'h01
`define EBA_WORD_ZERO 32'h0000_0000
`define EBA_BIT_ADDR_MAX 8'h3F
`define EBA_MSB 7
`define EBA_LSB 0
`define EBA_HI_SEVEN 7:1
`define EBA_LO_SEVEN 6:0
`define EBA_NIB_HI 7:4
`define EBA_NIB_LO 3:0
`define EBA_CY_BIT 8
`define EBA_HC_BIT 4
`define EBA_REG_WREG 4'h0
`define EBA_REG_FLAGS 4'h4
`define EBA_REG_STATUS 4'h8
`define EBA_FLAG_Z 0
`define EBA_FLAG_C 1
`define EBA_FLAG_HALF_CARRY 2
`define EBA_FLAG_SIGNED_RANGE 3
`define EBA_STS_SKIP 0
`define EBA_STS_BITERR 1
`endif

/* inc/eba_pkg.sv */
// Types shared by the eight-bit ALU datapath
package eba_pkg;
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD_AI = 6'h01, OP_ADD_AM = 6'h02, OP_ADD_MA = 6'h03,
        OP_ADDC_AM = 6'h04, OP_ADDC_MA = 6'h05, OP_ADDC_A = 6'h06, OP_ADDC_M = 6'h07,
        OP_NADD_AM = 6'h08, OP_NADD_MA = 6'h09, OP_SUB_AI = 6'h0A, OP_SUB_AM = 6'h0B,
        OP_SUB_MA = 6'h0C, OP_SUBC_AM = 6'h0D, OP_SUBC_MA = 6'h0E, OP_SUBC_A = 6'h0F,
        OP_SUBC_M = 6'h10, OP_INC_M = 6'h11, OP_DEC_M = 6'h12, OP_CLEAR_M = 6'h13,
        OP_SHR_A = 6'h14, OP_SHR_M = 6'h15, OP_RRC_A = 6'h16, OP_RRC_M = 6'h17,
        OP_SHL_A = 6'h18, OP_SHL_M = 6'h19, OP_RLC_A = 6'h1A, OP_RLC_M = 6'h1B,
        OP_SWAP_A = 6'h1C, OP_AND_AI = 6'h1D, OP_AND_AM = 6'h1E, OP_AND_MA = 6'h1F,
        OP_OR_AI = 6'h20, OP_OR_AM = 6'h21, OP_OR_MA = 6'h22, OP_XOR_AI = 6'h23,
        OP_XOR_AM = 6'h24, OP_XOR_MA = 6'h25, OP_XOR_IOA = 6'h26, OP_NOT_A = 6'h27,
        OP_NOT_M = 6'h28, OP_NEG_A = 6'h29, OP_NEG_M = 6'h2A, OP_COMP_AM = 6'h2B,
        OP_COMP_MA = 6'h2C, OP_BCLR_IO = 6'h2D, OP_BSET_IO = 6'h2E, OP_BCLR_M = 6'h2F,
        OP_BSET_M = 6'h30, OP_SWAPC_IO = 6'h31, OP_CEQSN_AI = 6'h32
    } eba_op_t;

    // Result of one add or subtract with its flags
    typedef struct packed {
        logic signed_range;
        logic half_carry;
        logic c;
        logic [7:0] res;
    } eba_arith_t;

    // Whole state of the datapath
    typedef struct packed {
        logic [7:0] wreg;
        logic z;
        logic c;
        logic half_carry;
        logic signed_range;
        logic mem_we;
        logic io_we;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic skip;
        logic bit_err;
        logic bus_ack;
        logic [31:0] rdata;
    } eba_state_t;
endpackage

/* verification/eba_core_tb_top.sv */
// Self-checking testbench of the eight-bit ALU datapath
`timescale 1ns/10ps
module eba_core_tb_top
    import eba_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic exec = 1'b0;
    eba_op_t op = OP_NOP;
    logic [7:0] imm = 8'h00;
    logic [7:0] addr = 8'h00;
    logic dir = 1'b0;
    logic [3:0] av_addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [7:0] mrd, iord, wreg, waddr, wdata, q;
    logic fz, fc, fac, fov, mwe, iowe, skip, berr, wreq;
    logic [31:0] rdat;
    logic [7:0] sel = 8'h3F;
    logic [2:0] bn = 3'h3;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    eba_core dut (.CLK_I(clk), .RST_I(rst), .EXEC_I(exec), .OP_I(op), .IMM_I(imm),
        .ADDR_I(addr), .BIT_I(bn), .MEM_RDATA_I(mrd), .IO_RDATA_I(iord),
        .IO_DIR_OUT_I(dir), .WREG_O(wreg), .FLAG_Z_O(fz), .FLAG_C_O(fc),
        .FLAG_HALF_CARRY_O(fac), .FLAG_SIGNED_RANGE_O(fov), .MEM_WE_O(mwe), .IO_WE_O(iowe),
        .WADDR_O(waddr), .WDATA_O(wdata),
        .SKIP_O(skip), .BIT_ERR_O(berr), .ADDRESS_I(av_addr), .READ_I(rd), .WRITE_I(wr),
        .WRITEDATA_I(wdat), .BYTEENABLE_I(4'hF), .READDATA_O(rdat), .WAITREQUEST_O(wreq));
    eba_mem_model prt (.clk_i(clk), .mem_we_i(mwe), .io_we_i(iowe), .waddr_i(waddr),
        .wdata_i(wdata), .addr_i(addr), .mem_rdata_o(mrd), .io_rdata_o(iord));

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic results;
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            results;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One Avalon transfer; holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        av_addr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h00_0000, d};
        do @(posedge clk); while (wreq !== 1'b0 && cyc < 5000);
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Preload register, flags and operand, run one op, judge every result
    // Destination: 0 register, 1 memory, 2 none, 3 IO (also output pin direction)
    task automatic run(input eba_op_t o, input logic [7:0] a, input logic [7:0] m,
        input logic [3:0] fi, input logic [7:0] res, input logic [3:0] fo, input int dst);
        bus(1'b1, 4'h0, a);
        bus(1'b1, 4'h4, {4'h0, fi});
        prt.mem[sel] <= m;
        prt.io[sel] <= m;
        @(posedge clk);
        exec <= 1'b1;
        op <= o;
        imm <= m;
        addr <= sel;
        dir <= (dst == 3);
        @(posedge clk);
        exec <= 1'b0;
        #1;
        chk(wreg, (dst == 0) ? res : a, "working register");
        chk({4'h0, fov, fac, fc, fz}, {4'h0, fo}, "flags");
        chk({6'h00, mwe, iowe}, {6'h00, dst == 1, dst == 3}, "write strobes");
        if (dst[0]) begin
            chk(wdata, res, "write data");
            chk(waddr, sel, "write address");
        end
        chk({7'h00, skip}, {7'h00, o == OP_CEQSN_AI && a == m}, "skip");
    endtask

    // Main sequence; flags written as {ov, ac, c, z}
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({wreg[3:0], fov, fac, fc, fz}, 8'h00, "after reset");
        run(OP_ADD_AM, 8'h0F, 8'h01, 4'h0, 8'h10, 4'h4, 0);
        run(OP_ADD_MA, 8'h80, 8'h80, 4'h0, 8'h00, 4'hB, 1);
        run(OP_ADD_AI, 8'h7F, 8'h01, 4'h0, 8'h80, 4'hC, 0);
        run(OP_ADDC_MA, 8'hF0, 8'h0F, 4'h2, 8'h00, 4'h7, 1);
        run(OP_ADDC_A, 8'hFF, 8'h00, 4'h2, 8'h00, 4'h7, 0);
        run(OP_ADDC_M, 8'h00, 8'hFF, 4'h2, 8'h00, 4'h7, 1);
        run(OP_NADD_AM, 8'h01, 8'h00, 4'h0, 8'hFF, 4'h6, 0);
        run(OP_NADD_MA, 8'h00, 8'h01, 4'h0, 8'hFF, 4'h6, 1);
        run(OP_SUB_AI, 8'h10, 8'h01, 4'h0, 8'h0F, 4'h4, 0);
        run(OP_SUB_AM, 8'h80, 8'h01, 4'h0, 8'h7F, 4'hC, 0);
        run(OP_SUB_MA, 8'h05, 8'h05, 4'h0, 8'h00, 4'h1, 1);
        run(OP_SUBC_MA, 8'h0F, 8'h10, 4'h2, 8'h00, 4'h5, 1);
        run(OP_SUBC_A, 8'h00, 8'h00, 4'h2, 8'hFF, 4'h6, 0);
        run(OP_SUBC_M, 8'h00, 8'h01, 4'h2, 8'h00, 4'h1, 1);
        run(OP_INC_M, 8'h00, 8'h7F, 4'h0, 8'h80, 4'hC, 1);
        run(OP_DEC_M, 8'h00, 8'h00, 4'h0, 8'hFF, 4'h6, 1);
        run(OP_CLEAR_M, 8'h00, 8'h5A, 4'hF, 8'h00, 4'hF, 1);
        run(OP_SHR_A, 8'h81, 8'h00, 4'hD, 8'h40, 4'hF, 0);
        run(OP_SHR_M, 8'h00, 8'h01, 4'h0, 8'h00, 4'h2, 1);
        run(OP_RRC_A, 8'h01, 8'h00, 4'h2, 8'h80, 4'h2, 0);
        run(OP_RRC_M, 8'h00, 8'h02, 4'h2, 8'h81, 4'h0, 1);
        run(OP_SHL_A, 8'h7F, 8'h00, 4'hF, 8'hFE, 4'hD, 0);
        run(OP_SHL_M, 8'h00, 8'h80, 4'h0, 8'h00, 4'h2, 1);
        run(OP_RLC_A, 8'h80, 8'h00, 4'hA, 8'h01, 4'hA, 0);
        run(OP_RLC_M, 8'h00, 8'h40, 4'h0, 8'h80, 4'h0, 1);
        run(OP_SWAP_A, 8'h3C, 8'h00, 4'h5, 8'hC3, 4'h5, 0);
        run(OP_AND_AI, 8'hF0, 8'h0F, 4'hE, 8'h00, 4'hF, 0);
        run(OP_AND_MA, 8'h0F, 8'hFF, 4'h6, 8'h0F, 4'h6, 1);
        run(OP_OR_AI, 8'h01, 8'h02, 4'h1, 8'h03, 4'h0, 0);
        run(OP_OR_MA, 8'h00, 8'h00, 4'hE, 8'h00, 4'hF, 1);
        run(OP_XOR_AI, 8'h55, 8'h55, 4'h0, 8'h00, 4'h1, 0);
        run(OP_XOR_MA, 8'hFF, 8'h0F, 4'h6, 8'hF0, 4'h6, 1);
        run(OP_XOR_IOA, 8'hFF, 8'h0F, 4'h5, 8'hF0, 4'h5, 3);
        run(OP_NOT_M, 8'h00, 8'hFF, 4'h6, 8'h00, 4'h7, 1);
        run(OP_NEG_A, 8'h38, 8'h00, 4'h0, 8'hC8, 4'h0, 0);
        run(OP_COMP_AM, 8'h38, 8'h42, 4'h0, 8'h00, 4'h2, 2);
        run(OP_COMP_MA, 8'h38, 8'h38, 4'h0, 8'h00, 4'h1, 2);
        run(OP_BCLR_IO, 8'h00, 8'hFF, 4'h5, 8'hF7, 4'h5, 3);
        run(OP_BSET_M, 8'h00, 8'h00, 4'hA, 8'h08, 4'hA, 1);
        run(OP_SWAPC_IO, 8'h00, 8'h00, 4'h2, 8'h08, 4'h0, 3);
        run(OP_SWAPC_IO, 8'h00, 8'h08, 4'h0, 8'h00, 4'h2, 2);
        run(OP_CEQSN_AI, 8'h55, 8'h55, 4'h0, 8'h00, 4'h1, 2);
        run(OP_CEQSN_AI, 8'h55, 8'h56, 4'h0, 8'h00, 4'h6, 2);
        // Remaining decoded forms, so every operation code except OP_NOP is exercised at least once
        run(OP_ADDC_AM, 8'h7F, 8'h00, 4'h2, 8'h80, 4'hC, 0);
        run(OP_SUBC_AM, 8'h10, 8'h0F, 4'h2, 8'h00, 4'h5, 0);
        run(OP_AND_AM, 8'hF0, 8'h3C, 4'hE, 8'h30, 4'hE, 0);
        run(OP_OR_AM, 8'h00, 8'h00, 4'h0, 8'h00, 4'h1, 0);
        run(OP_XOR_AM, 8'hA5, 8'h5A, 4'hF, 8'hFF, 4'hE, 0);
        run(OP_NOT_A, 8'h38, 8'h00, 4'h0, 8'hC7, 4'h0, 0);
        run(OP_NEG_M, 8'h00, 8'h38, 4'hF, 8'hC8, 4'hE, 1);
        run(OP_BSET_IO, 8'h00, 8'h00, 4'h0, 8'h08, 4'h0, 3);
        // Another bit number, so the bit select is not stuck at one value
        bn <= 3'h7;
        run(OP_BCLR_M, 8'h00, 8'hFF, 4'hA, 8'h7F, 4'hA, 1);
        // First address past the bit-addressable range must be refused
        sel <= 8'h40;
        run(OP_BSET_M, 8'h00, 8'h00, 4'h5, 8'h00, 4'h5, 2);
        chk({7'h00, berr}, 8'h01, "bit range error");
        bus(1'b0, 4'h8, 8'h00);
        chk(q & 8'h02, 8'h02, "status error bit");
        bus(1'b1, 4'h8, 8'h02);
        bus(1'b0, 4'h8, 8'h00);
        chk(q, 8'h00, "status after clear");
        bus(1'b0, 4'hC, 8'h00);
        chk(q, 8'h00, "unmapped read");
        results;
    end
endmodule

/* verification/eba_mem_model.sv */
// Behavioural data memory and IO register space facing the datapath
`timescale 1ns/10ps
module eba_mem_model (
    // Clock
    input wire logic clk_i,
    // Write side from the datapath
    input wire logic mem_we_i,
    input wire logic io_we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read side toward the datapath
    input wire logic [7:0] addr_i,
    output logic [7:0] mem_rdata_o,
    output logic [7:0] io_rdata_o
);
    logic [7:0] mem [256];
    logic [7:0] io [256];
    // Known contents from time zero, so no unknown reaches the operands
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
            io[i] = 8'h00;
        end
    end
    // Reads are combinational, as a one-cycle core sees its RAM
    assign mem_rdata_o = mem[addr_i];
    assign io_rdata_o = io[addr_i];
    // Writes land on the edge after the strobe rises
    always @(posedge clk_i) begin
        if (mem_we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (io_we_i) begin
            io[waddr_i] <= wdata_i;
        end
    end
endmodule
